// *** logic/trp_map.svh ***
// Purpose: Constants of the threshold and parity register bank
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef TRP_MAP_SVH
`define TRP_MAP_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define TRP_THR_W        16
`define TRP_ACQ_W        6
`define TRP_MODE_W       11
`define TRP_CHAN_W       5

// ----------------------------------------
// Channel range
// ----------------------------------------
`define TRP_CHAN_FIRST   5'h09
`define TRP_CHAN_LAST    5'h11
`define TRP_NUM_CHAN     9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TRP_THR_RST      16'h0000
`define TRP_ACQ_RST      6'h00
`define TRP_MODE_RST     11'h300

// ----------------------------------------
// Mode and status fields
// ----------------------------------------
`define TRP_MODE_PAR_BIT 0
`define TRP_STATUS_BASE  16'h0018
`define TRP_STATUS_SIDE  0

`endif

// *** logic/trp_pkg.sv ***
// Purpose: Types of the threshold and parity register bank
// Assumes: Constants come from trp_map.svh
// Notes:   Opcode codes are local to this block
`default_nettype none
`include "trp_map.svh"

package trp_pkg;

  typedef enum logic [2:0] {
    TRP_OP_THR_WR  = 3'h0,
    TRP_OP_THR_RD  = 3'h1,
    TRP_OP_ACQ_WR  = 3'h2,
    TRP_OP_ACQ_RD  = 3'h3,
    TRP_OP_RESET   = 3'h4,
    TRP_OP_STATUS  = 3'h5,
    TRP_OP_MODE_WR = 3'h6,
    TRP_OP_MODE_RD = 3'h7
  } trp_op_t;

  typedef struct packed {
    trp_op_t                 op;
    logic [`TRP_CHAN_W-1:0]  chan;
    logic [`TRP_THR_W-1:0]   arg;
  } trp_cmd_t;

  typedef struct packed {
    logic [`TRP_THR_W-1:0]   data;
    logic                    parity;
  } trp_ret_t;

endpackage : trp_pkg

`default_nettype wire

// *** logic/trp_regs.sv ***
// Purpose: Command-driven threshold, acquisition-time and mode registers
// Assumes: Commands arrive decoded, one per valid cycle, synchronous to clk_i
// Notes:   Every read-type command answers one cycle later with a parity-tagged word
//
// Summary of operation
// - Each of channels 9 to 17 keeps a 16-bit threshold; read returns the last written value, other channels read 0.
// - Channels 9 to 17 each have their own threshold register.
// - A 6-bit acquisition-time register accepts and returns any value 0 to 63.
// - The reset command restores every commandable register to its initial value.
// - Every register bit is writable and reads back unchanged.
// - The status command returns 24 in nominal operation.
// - Mode value 769 selects even parity on returned data.
// - Mode value 768 selects odd parity, the nominal setting.
// - Status bit 0 shows the selected receive side, one meaning secondary.
`timescale 1ns/10ps
`default_nettype none
`include "trp_map.svh"

module trp_regs (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               sys_rst_i,
  // Command port
  input  wire logic               cmd_valid_i,
  input  var  trp_pkg::trp_cmd_t  cmd_i,
  // Receive side currently selected
  input  wire logic               rx_side_i,
  // Return data
  output logic                    rsp_valid_o,
  output trp_pkg::trp_ret_t       rsp_o,
  // Register contents to the front end
  output logic [`TRP_ACQ_W-1:0]   acq_time_o,
  output logic                    even_parity_o
);

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic                  chan_ok;
  logic [3:0]            chan_idx;
  logic                  do_reset;

  assign chan_ok  = (cmd_i.chan >= `TRP_CHAN_FIRST) && (cmd_i.chan <= `TRP_CHAN_LAST);
  assign chan_idx = 4'(cmd_i.chan - `TRP_CHAN_FIRST);
  assign do_reset = cmd_valid_i && (cmd_i.op == trp_pkg::TRP_OP_RESET);

  // ----------------------------------------
  // Threshold registers
  // ----------------------------------------
  logic [`TRP_THR_W-1:0] thr_q [`TRP_NUM_CHAN];

  genvar gi;
  generate
    for (gi = 0; gi < `TRP_NUM_CHAN; gi++)
    begin : g_thr
      logic [`TRP_THR_W-1:0] thr_d;
      always_comb
      begin
        thr_d = thr_q[gi];
        if (do_reset)
          thr_d = `TRP_THR_RST;
        else if (cmd_valid_i && cmd_i.op == trp_pkg::TRP_OP_THR_WR && chan_ok && chan_idx == 4'(gi))
          thr_d = cmd_i.arg;
      end
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
          thr_q[gi] <= `TRP_THR_RST;
        else
          thr_q[gi] <= thr_d;
      end
    end
  endgenerate

  // ----------------------------------------
  // Acquisition time and mode
  // ----------------------------------------
  logic [`TRP_ACQ_W-1:0]  acq_d,  acq_q;
  logic [`TRP_MODE_W-1:0] mode_d, mode_q;

  always_comb
  begin
    acq_d  = acq_q;
    mode_d = mode_q;
    if (do_reset)
    begin
      acq_d  = `TRP_ACQ_RST;
      mode_d = `TRP_MODE_RST;
    end
    else if (cmd_valid_i && cmd_i.op == trp_pkg::TRP_OP_ACQ_WR)
      acq_d = cmd_i.arg[`TRP_ACQ_W-1:0];
    else if (cmd_valid_i && cmd_i.op == trp_pkg::TRP_OP_MODE_WR)
      mode_d = cmd_i.arg[`TRP_MODE_W-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      acq_q  <= `TRP_ACQ_RST;
      mode_q <= `TRP_MODE_RST;
    end
    else
    begin
      acq_q  <= acq_d;
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------
  // Return word
  // ----------------------------------------
  logic                  rsp_valid_d, rsp_valid_q;
  trp_pkg::trp_ret_t     rsp_d,       rsp_q;
  logic [`TRP_THR_W-1:0] word;
  logic                  answer;
  logic                  even_sel;

  // Parity follows the mode in force when the answer is formed
  assign even_sel = mode_q[`TRP_MODE_PAR_BIT];

  always_comb
  begin
    word   = '0;
    answer = 1'b0;
    if (cmd_valid_i)
    begin
      case (cmd_i.op)
        trp_pkg::TRP_OP_THR_RD:
        begin
          answer = 1'b1;
          word   = chan_ok ? thr_q[chan_idx] : '0;
        end
        trp_pkg::TRP_OP_ACQ_RD:
        begin
          answer = 1'b1;
          word   = {{(`TRP_THR_W-`TRP_ACQ_W){1'b0}}, acq_q};
        end
        trp_pkg::TRP_OP_MODE_RD:
        begin
          answer = 1'b1;
          word   = {{(`TRP_THR_W-`TRP_MODE_W){1'b0}}, mode_q};
        end
        trp_pkg::TRP_OP_STATUS:
        begin
          answer = 1'b1;
          word   = `TRP_STATUS_BASE;
          word[`TRP_STATUS_SIDE] = rx_side_i;
        end
        default:
        begin
          answer = 1'b0;
          word   = '0;
        end
      endcase
    end
    rsp_valid_d = answer;
    rsp_d.data  = word;
    // Odd parity makes the total count of ones odd
    rsp_d.parity = even_sel ? (^word) : ~(^word);
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
    end
    else
    begin
      rsp_valid_q <= rsp_valid_d;
      rsp_q       <= rsp_d;
    end
  end

  assign rsp_valid_o   = rsp_valid_q;
  assign rsp_o         = rsp_q;
  assign acq_time_o    = acq_q;
  assign even_parity_o = mode_q[`TRP_MODE_PAR_BIT];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  thr_readback_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cmd_valid_i && cmd_i.op == trp_pkg::TRP_OP_THR_WR && cmd_i.chan == 5'h09 ##1
    cmd_valid_i && cmd_i.op == trp_pkg::TRP_OP_THR_RD && cmd_i.chan == 5'h09
    |=> rsp_valid_o && rsp_o.data == $past(cmd_i.arg, 2))
    else $error("threshold read differs from write");

  thr_chan_map_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cmd_valid_i && cmd_i.op == trp_pkg::TRP_OP_THR_WR && chan_ok
    |=> thr_q[$past(chan_idx)] == $past(cmd_i.arg))
    else $error("threshold write missed its channel");

  acq_readback_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cmd_valid_i && cmd_i.op == trp_pkg::TRP_OP_ACQ_WR
    |=> acq_time_o == $past(cmd_i.arg[`TRP_ACQ_W-1:0]))
    else $error("acquisition time not stored");

  reset_cmd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    do_reset |=> acq_time_o == `TRP_ACQ_RST && mode_q == `TRP_MODE_RST
      && thr_q[0] == `TRP_THR_RST && thr_q[8] == `TRP_THR_RST)
    else $error("reset command left a register set");

  status_value_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cmd_valid_i && cmd_i.op == trp_pkg::TRP_OP_STATUS && !rx_side_i
    |=> rsp_valid_o && rsp_o.data == 16'h0018)
    else $error("status is not 24");

  status_side_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cmd_valid_i && cmd_i.op == trp_pkg::TRP_OP_STATUS |=> rsp_o.data[0] == $past(rx_side_i))
    else $error("status side bit wrong");

  even_mode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cmd_valid_i && cmd_i.op == trp_pkg::TRP_OP_MODE_WR && cmd_i.arg == 16'h0301
    |=> even_parity_o)
    else $error("769 did not select even parity");

  odd_mode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cmd_valid_i && cmd_i.op == trp_pkg::TRP_OP_MODE_WR && cmd_i.arg == 16'h0300
    |=> !even_parity_o)
    else $error("768 did not select odd parity");

  parity_word_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rsp_valid_o |-> (^{rsp_o.data, rsp_o.parity}) == !$past(even_sel))
    else $error("return parity wrong");

  thr_isolate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cmd_valid_i && cmd_i.op == trp_pkg::TRP_OP_THR_WR && cmd_i.chan == 5'h0A
    |=> $stable(thr_q[0]) && $stable(acq_time_o))
    else $error("threshold write disturbed another register");

  thr_rd_c:    cover property (@(posedge clk_i) cmd_valid_i && cmd_i.op == trp_pkg::TRP_OP_THR_RD ##1 rsp_valid_o);
  even_par_c:  cover property (@(posedge clk_i) even_parity_o && rsp_valid_o);
  reset_cmd_c: cover property (@(posedge clk_i) do_reset);
  side_b_c:    cover property (@(posedge clk_i) rsp_valid_o && rsp_o.data == 16'h0019);

endmodule : trp_regs

`default_nettype wire

// *** verification/test_threshold_parity_regs.sv ***
// Purpose: Self-checking bench of the threshold and parity register bank
// Assumes: One command per cycle, answer one cycle after it is taken
// Notes:   Random data from a fixed seed, corner patterns among it
`timescale 1ns/10ps
`default_nettype none

module test_threshold_parity_regs;
  logic              clk_i       = 1'b0;
  logic              sys_rst_i   = 1'b1;
  logic              cmd_valid_i = 1'b0;
  trp_pkg::trp_cmd_t cmd_i       = '0;
  logic              rx_side_i   = 1'b0;
  logic              rsp_valid_o;
  trp_pkg::trp_ret_t rsp_o;
  logic [5:0]        acq_time_o;
  logic              even_parity_o;
  logic              par_err;
  logic              even_q      = 1'b0;
  int                n_errors    = 0;
  int                check_count = 0;
  logic [15:0]       shadow [9:17];
  logic [15:0]       pat [4]     = '{16'h0000, 16'h5555, 16'hAAAA, 16'h045A};
  logic [5:0]        acq [5]     = '{6'h00, 6'h15, 6'h2A, 6'h3F, 6'h00};

  always #5 clk_i = ~clk_i;

  trp_regs u_trp_regs (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .rx_side_i(rx_side_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .acq_time_o(acq_time_o),
    .even_parity_o(even_parity_o));
  trp_ctrl_model u_trp_ctrl_model (.rsp_valid_i(rsp_valid_o), .rsp_i(rsp_o), .par_err_o(par_err));

  // ----------------------------------------
  // Expectations and checks
  // ----------------------------------------
  function automatic logic exp_par(input logic [15:0] d, input logic ev);
    return ev ? ^d : ~^d;
  endfunction

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input trp_pkg::trp_op_t op, input logic [4:0] ch, input logic [15:0] arg);
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i       <= trp_pkg::trp_cmd_t'{op, ch, arg};
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    #1;
  endtask

  // Threshold write and read of one channel in consecutive cycles
  task automatic wr_rd(input logic [4:0] ch, input logic [15:0] arg);
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i       <= trp_pkg::trp_cmd_t'{trp_pkg::TRP_OP_THR_WR, ch, arg};
    @(posedge clk_i);
    cmd_i       <= trp_pkg::trp_cmd_t'{trp_pkg::TRP_OP_THR_RD, ch, 16'h0000};
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input trp_pkg::trp_op_t op, input logic [4:0] ch, input logic [15:0] exp);
    cmd(op, ch, 16'h0000);
    chk({rsp_valid_o, rsp_o.data}, {1'b1, exp});
    chk(rsp_o.parity, exp_par(exp, even_q));
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_errors++;
    give_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [15:0] v;
    void'($urandom(32'h717c_40e0));
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(trp_pkg::TRP_OP_MODE_RD, 5'h00, 16'h0300);
    for (int c = 9; c <= 17; c++)
    begin
      rd(trp_pkg::TRP_OP_THR_RD, 5'(c), 16'h0000);
      for (int p = 0; p < 5; p++)
      begin
        v = (p < 4) ? pat[p] : 16'($urandom);
        cmd(trp_pkg::TRP_OP_THR_WR, 5'(c), v);
        chk(rsp_valid_o, 1'b0);
        rd(trp_pkg::TRP_OP_THR_RD, 5'(c), v);
      end
      shadow[c] = v;
    end
    v = 16'($urandom);
    wr_rd(5'h09, v);
    chk({rsp_valid_o, rsp_o.data}, {1'b1, v});
    chk(rsp_o.parity, exp_par(v, 1'b0));
    shadow[9] = v;
    cmd(trp_pkg::TRP_OP_THR_WR, 5'h08, 16'hFFFF);
    rd(trp_pkg::TRP_OP_THR_RD, 5'h08, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      v = {10'h000, (i < 5) ? acq[i] : 6'($urandom)};
      cmd(trp_pkg::TRP_OP_ACQ_WR, 5'h00, v);
      chk(acq_time_o, v[5:0]);
      rd(trp_pkg::TRP_OP_ACQ_RD, 5'h00, v);
    end
    for (int c = 9; c <= 17; c++)
      rd(trp_pkg::TRP_OP_THR_RD, 5'(c), shadow[c]);
    for (int s = 0; s < 4; s++)
    begin
      even_q = s[1];
      rx_side_i <= s[0];
      cmd(trp_pkg::TRP_OP_MODE_WR, 5'h00, {15'h0180, s[1]});
      chk(even_parity_o, s[1]);
      rd(trp_pkg::TRP_OP_MODE_RD, 5'h00, {15'h0180, s[1]});
      rd(trp_pkg::TRP_OP_STATUS, 5'h00, {15'h000C, s[0]});
      chk(par_err, s[1]);
    end
    cmd(trp_pkg::TRP_OP_RESET, 5'h00, 16'h0000);
    even_q = 1'b0;
    chk(even_parity_o, 1'b0);
    rd(trp_pkg::TRP_OP_THR_RD, 5'h0D, 16'h0000);
    rd(trp_pkg::TRP_OP_ACQ_RD, 5'h00, 16'h0000);
    rd(trp_pkg::TRP_OP_MODE_RD, 5'h00, 16'h0300);
    cmd(trp_pkg::TRP_OP_ACQ_WR, 5'h00, 16'h003F);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk(acq_time_o, 6'h00);
    rd(trp_pkg::TRP_OP_MODE_RD, 5'h00, 16'h0300);
    give_verdict();
  end
endmodule // test_threshold_parity_regs

`default_nettype wire

// *** verification/trp_ctrl_model.sv ***
// Purpose: Controller-side receiver of return words
// Assumes: Return words arrive with a one-cycle valid strobe
// Notes:   Accepts odd parity only
`timescale 1ns/10ps
`default_nettype none

module trp_ctrl_model (
  // Return data from the device
  input  wire logic               rsp_valid_i,
  input  var  trp_pkg::trp_ret_t  rsp_i,
  // Parity fault on the current word
  output logic                    par_err_o
);
  assign par_err_o = rsp_valid_i & ~(^rsp_i);
endmodule // trp_ctrl_model

`default_nettype wire
